/* File: logic/rlu_regs.sv */
// direct register tail of the transceiver interface unit: received_signal_strength limit, user pins, test, config window
//
// What this block does
// - flag bit 7 goes to one when converted received_signal_strength is at or above the limit.
// - flag goes to zero when converted received_signal_strength is below the limit; status only.
// - seven-bit threshold resets to zero; at-or-above raises the clear channel indication.
// - pcmcia mode with high enable drives the high pin with inverted bit 7.
// - otherwise bit 7 written data has no effect on the high pin.
// - read of bit 7 always returns the inverted high pin level.
// - each low pin driven with its data bit when enabled and pcmcia strap set.
// - reads of low data bits return the pin levels regardless of enable or strap.
// - seven-bit test command resets to zero; zero means normal operation.
// - sixty-four registers in all, thirty-two reachable directly from core and host.
// - write the index register, then access the data port to reach that register.
module rlu_regs
  import rlu_pkg::*;
(
  input  wire logic                     sys_clk,              // device clock, 125 mhz
  input  wire logic                     rst,                  // synchronous reset, active high
  // direct register port from core or bus interface unit
  input  wire logic [DIRECT_ADDR_W-1:0] reg_addr,             // direct register index
  input  wire logic                     reg_wr,               // write strobe, one cycle
  input  wire logic                     reg_rd,               // read strobe, one cycle
  input  wire logic [DATA_W-1:0]        reg_wdata,            // write data
  output logic      [DATA_W-1:0]        reg_rdata,            // read data
  output logic                          reg_rd_valid,         // read data valid pulse
  // indirect configuration register bank
  output logic      [CFG_INDEX_W-1:0]   cfg_index,            // selected indirect register
  output logic                          cfg_wr,               // indirect write pulse
  output logic                          cfg_rd,               // indirect read pulse
  output logic      [DATA_W-1:0]        cfg_wdata,            // indirect write data
  input  wire logic [DATA_W-1:0]        cfg_rdata,            // indirect read data, same cycle as cfg_rd
  input  wire logic [LOW_PIN_W-1:0]     low_user_pin_enable,  // from user pin enable register
  input  wire logic                     high_user_pin_enable, // from user pin enable register
  // mode strap and user pins
  input  wire logic                     pcmcia_mode_pin,      // interface mode strap, high for pcmcia
  input  wire logic [LOW_PIN_W-1:0]     low_user_pin_in,      // low user pin levels
  output logic      [LOW_PIN_W-1:0]     low_user_pin_out,     // low user pin drive value
  output logic      [LOW_PIN_W-1:0]     low_user_pin_oe,      // low user pin drive enable
  input  wire logic                     high_user_pin_in,     // high user pin level
  output logic                          high_user_pin_out,    // high user pin drive value
  output logic                          high_user_pin_oe,     // high user pin drive enable
  // signal strength path
  input  wire logic [RECEIVED_SIGNAL_STRENGTH_W-1:0]        received_signal_strength_value,           // converted signal strength
  input  wire logic                     received_signal_strength_valid,           // new conversion result
  output logic                          cca_received_signal_strength_ind,         // at-or-above indication to cca logic
  // test command
  output logic      [TC_W-1:0]          test_command_field,   // selected test mode
  output logic                          test_normal           // high while no test mode selected
);

  function automatic logic hits(input logic [DIRECT_ADDR_W-1:0] addr,
                                input logic [DIRECT_ADDR_W-1:0] idx);
    hits = (addr == idx);
  endfunction

  // ---- synchronised pin levels ----
  logic                 pcmcia_mode;
  logic [LOW_PIN_W-1:0] low_pin_level;
  logic                 high_pin_level;

  rlu_sync #(
    .WIDTH (1)
  ) u_sync_mode (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (pcmcia_mode_pin),
    .sync_out (pcmcia_mode)
  );

  rlu_sync #(
    .WIDTH (LOW_PIN_W + 1)
  ) u_sync_pins (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({high_user_pin_in, low_user_pin_in}),
    .sync_out ({high_pin_level, low_pin_level})
  );

  // ---- write decode ----
  logic wr_index;
  logic wr_data_port;
  logic wr_received_signal_strength_limit;
  logic wr_user_pin;
  logic wr_test_cmd;
  logic rd_data_port;

  // direct window only; indirect half sits behind the data port
  assign wr_index      = reg_wr && hits(reg_addr, IDX_CONFIG_INDEX);
  assign wr_data_port  = reg_wr && hits(reg_addr, IDX_CONFIG_DATA);
  assign wr_received_signal_strength_limit = reg_wr && hits(reg_addr, IDX_RECEIVED_SIGNAL_STRENGTH_LIMIT);
  assign wr_user_pin   = reg_wr && hits(reg_addr, IDX_USER_PIN);
  assign wr_test_cmd   = reg_wr && hits(reg_addr, IDX_TEST_CMD);
  assign rd_data_port  = reg_rd && hits(reg_addr, IDX_CONFIG_DATA);

  // ---- indirect configuration window ----
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_index <= CFG_INDEX_RESET;
    end else if (wr_index) begin
      cfg_index <= reg_wdata[CFG_INDEX_W-1:0];
    end
  end

  // data port access forwarded to whatever index is held
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_wr    <= 1'b0;
      cfg_rd    <= 1'b0;
      cfg_wdata <= DATA_ZERO;
    end else begin
      cfg_wr <= wr_data_port;
      cfg_rd <= rd_data_port;
      if (wr_data_port) begin
        cfg_wdata <= reg_wdata;
      end
    end
  end

  // ---- received_signal_strength lower limit ----
  logic [RECEIVED_SIGNAL_STRENGTH_W-1:0] received_signal_strength_threshold;
  logic              received_signal_strength_at_or_above_flag;

  rlu_received_signal_strength_cmp u_received_signal_strength_cmp (
    .sys_clk               (sys_clk),
    .rst                   (rst),
    .threshold_wr          (wr_received_signal_strength_limit),
    .threshold_wdata       (reg_wdata[RECEIVED_SIGNAL_STRENGTH_W-1:0]),
    .received_signal_strength_value            (received_signal_strength_value),
    .received_signal_strength_valid            (received_signal_strength_valid),
    .received_signal_strength_threshold        (received_signal_strength_threshold),
    .received_signal_strength_at_or_above_flag (received_signal_strength_at_or_above_flag),
    .cca_received_signal_strength_ind          (cca_received_signal_strength_ind)
  );

  // ---- user pin data ----
  logic [LOW_PIN_W-1:0] low_user_pin_data;
  logic                 high_user_pin_data;

  // reserved bits 6:5 are dropped on write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      low_user_pin_data  <= LOW_PIN_DATA_RESET;
      high_user_pin_data <= HIGH_PIN_DATA_RESET;
    end else if (wr_user_pin) begin
      low_user_pin_data  <= reg_wdata[LOW_PIN_W-1:0];
      high_user_pin_data <= reg_wdata[HIGH_PIN_BIT];
    end
  end

  logic [LOW_PIN_W-1:0] next_low_pin_oe;
  logic                 next_high_pin_oe;

  genvar p;
  generate
    for (p = 0; p < LOW_PIN_W; p++) begin : g_low_pin
      assign next_low_pin_oe[p] = low_user_pin_enable[p] && pcmcia_mode;
    end
  endgenerate

  assign next_high_pin_oe = pcmcia_mode && high_user_pin_enable;

  // pins follow the register one cycle behind a write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      low_user_pin_out <= LOW_PIN_DATA_RESET;
      low_user_pin_oe  <= '0;
    end else begin
      low_user_pin_out <= low_user_pin_data;
      low_user_pin_oe  <= next_low_pin_oe;
    end
  end

  // high pin carries the inverse of the stored bit
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      high_user_pin_out <= ~HIGH_PIN_DATA_RESET;
      high_user_pin_oe  <= 1'b0;
    end else begin
      high_user_pin_out <= ~high_user_pin_data;
      high_user_pin_oe  <= next_high_pin_oe;
    end
  end

  // ---- test command ----
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      test_command_field <= TC_RESET;
      test_normal        <= 1'b1;
    end else if (wr_test_cmd) begin
      // top bit discarded, held at zero by software
      test_command_field <= reg_wdata[TC_W-1:0];
      test_normal        <= (reg_wdata[TC_W-1:0] == TC_NORMAL);
    end
  end

  // ---- read path: two-cycle pipeline so data port reads line up ----
  logic                     rd_q;
  logic [DIRECT_ADDR_W-1:0] rd_addr_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_q      <= 1'b0;
      rd_addr_q <= '0;
    end else begin
      rd_q      <= reg_rd;
      if (reg_rd) begin
        rd_addr_q <= reg_addr;
      end
    end
  end

  logic [DATA_W-1:0] rd_received_signal_strength_limit;
  logic [DATA_W-1:0] rd_user_pin;
  logic [DATA_W-1:0] rd_index;
  logic [DATA_W-1:0] rd_test_cmd;
  logic [DATA_W-1:0] next_rdata;

  assign rd_received_signal_strength_limit = {received_signal_strength_at_or_above_flag, received_signal_strength_threshold};
  // reserved bits 6:5 read as zero
  assign rd_user_pin   = {~high_pin_level, 2'b00, low_pin_level};
  assign rd_index      = {{(DATA_W-CFG_INDEX_W){1'b0}}, cfg_index};
  assign rd_test_cmd   = {1'b0, test_command_field};

  // one select per mapped index; dummy and foreign indices select nothing and read as zero
  logic sel_data_port;
  logic sel_index;
  logic sel_received_signal_strength_limit;
  logic sel_user_pin;
  logic sel_test_cmd;

  assign sel_data_port  = hits(rd_addr_q, IDX_CONFIG_DATA);
  assign sel_index      = hits(rd_addr_q, IDX_CONFIG_INDEX);
  assign sel_received_signal_strength_limit = hits(rd_addr_q, IDX_RECEIVED_SIGNAL_STRENGTH_LIMIT);
  assign sel_user_pin   = hits(rd_addr_q, IDX_USER_PIN);
  assign sel_test_cmd   = hits(rd_addr_q, IDX_TEST_CMD);

  assign next_rdata = ({DATA_W{sel_data_port}}  & cfg_rdata)     |
                      ({DATA_W{sel_index}}      & rd_index)      |
                      ({DATA_W{sel_received_signal_strength_limit}} & rd_received_signal_strength_limit) |
                      ({DATA_W{sel_user_pin}}   & rd_user_pin)   |
                      ({DATA_W{sel_test_cmd}}   & rd_test_cmd);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata    <= DATA_ZERO;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= rd_q;
      if (rd_q) begin
        reg_rdata <= next_rdata;
      end
    end
  end

endmodule

/* File: inc/rlu_pkg.sv */
// constants for the received signal strength limit and user pin register tail
package rlu_pkg;

  // direct register window of the transceiver interface unit
  localparam int unsigned DIRECT_ADDR_W   = 5;
  localparam int unsigned DIRECT_COUNT    = 32;
  localparam int unsigned INDIRECT_COUNT  = 32;
  localparam int unsigned TOTAL_REG_COUNT = DIRECT_COUNT + INDIRECT_COUNT;
  localparam int unsigned DATA_W          = 8;

  // direct register indices
  localparam logic [DIRECT_ADDR_W-1:0] IDX_CONFIG_INDEX = 5'h18;
  localparam logic [DIRECT_ADDR_W-1:0] IDX_CONFIG_DATA  = 5'h19;
  localparam logic [DIRECT_ADDR_W-1:0] IDX_RECEIVED_SIGNAL_STRENGTH_LIMIT   = 5'h1c;
  localparam logic [DIRECT_ADDR_W-1:0] IDX_USER_PIN     = 5'h1d;
  localparam logic [DIRECT_ADDR_W-1:0] IDX_TEST_DUMMY   = 5'h1e;
  localparam logic [DIRECT_ADDR_W-1:0] IDX_TEST_CMD     = 5'h1f;

  // indirect configuration index
  localparam int unsigned CFG_INDEX_W = 5;
  localparam logic [CFG_INDEX_W-1:0] CFG_INDEX_RESET = 5'h00;

  // received_signal_strength limit register layout
  localparam int unsigned RECEIVED_SIGNAL_STRENGTH_W          = 7;
  localparam int unsigned RECEIVED_SIGNAL_STRENGTH_FLAG_BIT   = 7;
  localparam logic [RECEIVED_SIGNAL_STRENGTH_W-1:0] RECEIVED_SIGNAL_STRENGTH_THRESHOLD_RESET = 7'h00;

  // user pin register layout
  localparam int unsigned LOW_PIN_W     = 5;
  localparam int unsigned HIGH_PIN_BIT  = 7;
  localparam logic [LOW_PIN_W-1:0] LOW_PIN_DATA_RESET  = 5'h00;
  localparam logic                 HIGH_PIN_DATA_RESET = 1'b0;

  // test command register layout
  localparam int unsigned TC_W = 7;
  localparam logic [TC_W-1:0] TC_RESET  = 7'h00;
  localparam logic [TC_W-1:0] TC_NORMAL = 7'h00;

  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

endpackage

/* File: logic/rlu_sync.sv */
// two flip-flop synchroniser for pin levels, one chain per bit
module rlu_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             sys_clk,  // device clock
  input  wire logic             rst,      // synchronous reset, active high
  input  wire logic [WIDTH-1:0] async_in, // level from a pin
  output logic      [WIDTH-1:0] sync_out  // level in the sys_clk domain
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic stage1;
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          stage1      <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          stage1      <= async_in[i];
          sync_out[i] <= stage1;
        end
      end
    end
  endgenerate

endmodule

/* File: logic/rlu_received_signal_strength_cmp.sv */
// received_signal_strength lower limit threshold and at-or-above comparison
module rlu_received_signal_strength_cmp
  import rlu_pkg::*;
(
  input  wire logic              sys_clk,               // device clock
  input  wire logic              rst,                   // synchronous reset, active high
  input  wire logic              threshold_wr,          // write strobe for the threshold
  input  wire logic [RECEIVED_SIGNAL_STRENGTH_W-1:0] threshold_wdata,       // new threshold value
  input  wire logic [RECEIVED_SIGNAL_STRENGTH_W-1:0] received_signal_strength_value,            // converted signal strength
  input  wire logic              received_signal_strength_valid,            // new conversion result this cycle
  output logic      [RECEIVED_SIGNAL_STRENGTH_W-1:0] received_signal_strength_threshold,        // programmed lower limit
  output logic                   received_signal_strength_at_or_above_flag, // status flag
  output logic                   cca_received_signal_strength_ind           // indication to clear channel logic
);

  logic at_or_above;

  assign at_or_above = (received_signal_strength_value >= received_signal_strength_threshold);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      received_signal_strength_threshold <= RECEIVED_SIGNAL_STRENGTH_THRESHOLD_RESET;
    end else if (threshold_wr) begin
      received_signal_strength_threshold <= threshold_wdata;
    end
  end

  // only a new result moves the flag; a threshold change waits for it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      received_signal_strength_at_or_above_flag <= 1'b0;
      cca_received_signal_strength_ind          <= 1'b0;
    end else if (received_signal_strength_valid) begin
      received_signal_strength_at_or_above_flag <= at_or_above;
      cca_received_signal_strength_ind          <= at_or_above;
    end
  end

endmodule

/* File: test/rlu_regs_checker.sv */
// concurrent checks on the ports of the register tail
module rlu_regs_checker
  import rlu_pkg::*;
(
  input wire logic                     sys_clk,              // device clock
  input wire logic                     rst,                  // sync reset
  input wire logic [DIRECT_ADDR_W-1:0] reg_addr,             // register index
  input wire logic                     reg_wr,               // write strobe
  input wire logic                     reg_rd,               // read strobe
  input wire logic [DATA_W-1:0]        reg_wdata,            // write data
  input wire logic                     reg_rd_valid,         // read answer
  input wire logic [CFG_INDEX_W-1:0]   cfg_index,            // indirect index
  input wire logic                     cfg_wr,               // indirect write
  input wire logic [DATA_W-1:0]        cfg_wdata,            // indirect data
  input wire logic [LOW_PIN_W-1:0]     low_user_pin_enable,  // low enables
  input wire logic                     high_user_pin_enable, // high enable
  input wire logic                     pcmcia_mode_pin,      // mode strap
  input wire logic [LOW_PIN_W-1:0]     low_user_pin_out,     // low drive
  input wire logic [LOW_PIN_W-1:0]     low_user_pin_oe,      // low enable out
  input wire logic                     high_user_pin_out,    // high drive
  input wire logic                     high_user_pin_oe,     // high enable out
  input wire logic [RECEIVED_SIGNAL_STRENGTH_W-1:0]        received_signal_strength_value,           // strength
  input wire logic                     received_signal_strength_valid,           // new strength
  input wire logic                     cca_received_signal_strength_ind,         // indication
  input wire logic [TC_W-1:0]          test_command_field,   // test mode
  input wire logic                     test_normal           // normal mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [RECEIVED_SIGNAL_STRENGTH_W-1:0] thr;
  // shadow of the programmed lower limit
  always_ff @(posedge sys_clk) begin
    if (rst) thr <= RECEIVED_SIGNAL_STRENGTH_THRESHOLD_RESET;
    else if (reg_wr && reg_addr == IDX_RECEIVED_SIGNAL_STRENGTH_LIMIT) thr <= reg_wdata[RECEIVED_SIGNAL_STRENGTH_W-1:0];
  end
  sequence wr_at(logic [DIRECT_ADDR_W-1:0] a); reg_wr && reg_addr == a; endsequence
  sequence rd_ans; ##2 reg_rd_valid; endsequence
  read_lat_a: assert property (reg_rd |-> rd_ans) else $error("read answer late");
  read_src_a: assert property (reg_rd_valid |-> $past(reg_rd, 2)) else $error("stray read answer");
  received_signal_strength_cmp_a: assert property (received_signal_strength_valid |=> cca_received_signal_strength_ind == ($past(received_signal_strength_value) >= $past(thr)))
    else $error("limit compare wrong");
  received_signal_strength_hold_a: assert property (!received_signal_strength_valid |=> $stable(cca_received_signal_strength_ind)) else $error("indication moved");
  high_drv_a: assert property (wr_at(IDX_USER_PIN) |=> ##1 high_user_pin_out == !$past(reg_wdata[HIGH_PIN_BIT], 2))
    else $error("high pin value wrong");
  low_drv_a: assert property ((pcmcia_mode_pin && high_user_pin_enable)[*4] |->
    high_user_pin_oe && low_user_pin_oe == $past(low_user_pin_enable)) else $error("pin enable wrong");
  no_drive_a: assert property ((!pcmcia_mode_pin)[*4] |-> !high_user_pin_oe && low_user_pin_oe == 5'h00)
    else $error("pin driven in isa mode");
  cfg_port_a: assert property (wr_at(IDX_CONFIG_DATA) |=> cfg_wr && cfg_wdata == $past(reg_wdata))
    else $error("data port write lost");
  cfg_idx_a: assert property (wr_at(IDX_CONFIG_INDEX) |=> cfg_index == $past(reg_wdata[4:0]))
    else $error("index not stored");
  test_cmd_a: assert property (wr_at(IDX_TEST_CMD) |=> test_command_field == $past(reg_wdata[6:0])
    && test_normal == ($past(reg_wdata[6:0]) == TC_NORMAL)) else $error("test command wrong");
endmodule

/* File: test/rlu_cfg_bank.sv */
// model of the indirect configuration register bank
module rlu_cfg_bank
  import rlu_pkg::*;
(
  input  wire logic                   sys_clk,   // device clock
  input  wire logic [CFG_INDEX_W-1:0] cfg_index, // selected register
  input  wire logic                   cfg_wr,    // write pulse
  input  wire logic                   cfg_rd,    // read pulse
  input  wire logic [DATA_W-1:0]      cfg_wdata, // write data
  output logic      [DATA_W-1:0]      cfg_rdata  // read data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem [INDIRECT_COUNT];
  logic [DATA_W-1:0] last = 8'h00;
  always @(posedge sys_clk) begin
    if (cfg_wr) mem[cfg_index] <= cfg_wdata;
    if (cfg_rd) last <= mem[cfg_index];
  end
  // idle bus shows the inverse of the last value
  assign cfg_rdata = cfg_rd ? mem[cfg_index] : ~last;
endmodule

/* File: test/rlu_regs_tb.sv */
// self-checking bench for the register tail
module rlu_regs_tb
  import rlu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, received_signal_strength_valid = 0, mode = 0, h_en = 0, h_ext = 1;
  logic [4:0] addr = 5'h00, l_en = 5'h00, l_ext = 5'h15, l_in, l_out, l_oe, cfg_index;
  logic [7:0] wdata = 8'h00, rdata, cfg_wdata, cfg_rdata, got;
  logic [6:0] received_signal_strength = 7'h00, tcf;
  logic h_in, h_out, h_oe, rd_valid, cfg_wr, cfg_rd, cca, tnorm;
  int failures = 0, total_checks = 0, cycles = 0;
  assign l_in = (l_out & l_oe) | (l_ext & ~l_oe);
  assign h_in = h_oe ? h_out : h_ext;
  rlu_regs i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(wdata), .reg_rdata(rdata), .reg_rd_valid(rd_valid), .cfg_index(cfg_index), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .low_user_pin_enable(l_en),
    .high_user_pin_enable(h_en), .pcmcia_mode_pin(mode), .low_user_pin_in(l_in), .low_user_pin_out(l_out),
    .low_user_pin_oe(l_oe), .high_user_pin_in(h_in), .high_user_pin_out(h_out), .high_user_pin_oe(h_oe),
    .received_signal_strength_value(received_signal_strength), .received_signal_strength_valid(received_signal_strength_valid), .cca_received_signal_strength_ind(cca), .test_command_field(tcf),
    .test_normal(tnorm));
  rlu_cfg_bank i_bank (.sys_clk(sys_clk), .cfg_index(cfg_index), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      close_out();
    end
  end
  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [4:0] a, logic [7:0] d);
    @(negedge sys_clk);
    reg_wr = 1; addr = a; wdata = d;
    @(negedge sys_clk);
    reg_wr = 0;
  endtask
  task automatic rd(logic [4:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_rd = 1; addr = a;
    @(negedge sys_clk);
    reg_rd = 0;
    d = 8'hxx;
    repeat (4) begin
      @(negedge sys_clk);
      if (rd_valid === 1'b1) begin d = rdata; break; end
    end
  endtask
  task automatic idle(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  initial begin
    logic [6:0] samples [5] = '{7'h3f, 7'h40, 7'h41, 7'h7f, 7'h00};
    idle(16);
    rst = 0;
    chk("high out", {7'h00, h_out}, 8'h01);
    rd(IDX_RECEIVED_SIGNAL_STRENGTH_LIMIT, got); chk("limit reset", got, 8'h00);
    rd(IDX_TEST_CMD, got); chk("test reset", got, 8'h00);
    wr(IDX_RECEIVED_SIGNAL_STRENGTH_LIMIT, 8'hc0);
    foreach (samples[i]) begin
      @(negedge sys_clk);
      received_signal_strength_valid = 1; received_signal_strength = samples[i];
      @(negedge sys_clk);
      received_signal_strength_valid = 0;
      chk("cca", {7'h00, cca}, {7'h00, samples[i] >= 7'h40});
      rd(IDX_RECEIVED_SIGNAL_STRENGTH_LIMIT, got); chk("limit", got, {samples[i] >= 7'h40, 7'h40});
    end
    mode = 1; l_en = 5'h15; h_en = 1;
    for (int m = 1; m >= 0; m--) begin
      mode = m[0];
      idle(5);
      wr(IDX_USER_PIN, 8'h8a);
      idle(4);
      chk("pins", {h_in, 2'b00, l_in}, mode ? {1'b0, 2'b00, 5'h0a & 5'h15 | l_ext & 5'h0a} : {h_ext, 2'b00, l_ext});
      rd(IDX_USER_PIN, got); chk("pin read", got, {~h_in, 2'b00, l_in});
    end
    mode = 1; h_en = 0; idle(5);
    chk("high off", {7'h00, h_in}, {7'h00, h_ext});
    mode = 0; h_ext = 0; l_ext = 5'h04; idle(5);
    rd(IDX_USER_PIN, got); chk("pin read isa", got, 8'h84);
    wr(IDX_CONFIG_INDEX, 8'h03); wr(IDX_CONFIG_DATA, 8'ha5);
    wr(IDX_CONFIG_INDEX, 8'h1f); wr(IDX_CONFIG_DATA, 8'h5a);
    wr(IDX_CONFIG_INDEX, 8'h03);
    rd(IDX_CONFIG_DATA, got); chk("indirect 03", got, 8'ha5);
    rd(IDX_CONFIG_INDEX, got); chk("index", got, 8'h03);
    wr(IDX_CONFIG_INDEX, 8'h1f);
    rd(IDX_CONFIG_DATA, got); chk("indirect 1f", got, 8'h5a);
    rd(5'h05, got); chk("unmapped", got, 8'h00);
    wr(IDX_TEST_DUMMY, 8'h00);
    rd(IDX_TEST_DUMMY, got); chk("dummy", got, 8'h00);
    wr(IDX_TEST_CMD, 8'h05);
    chk("normal", {7'h00, tnorm}, 8'h00);
    rd(IDX_TEST_CMD, got); chk("test cmd", got, 8'h05);
    wr(IDX_TEST_CMD, 8'h00);
    chk("normal back", {7'h00, tnorm}, 8'h01);
    close_out();
  end
endmodule
bind rlu_regs rlu_regs_checker i_chk (.*);
